// >>> core/isr_pkg.sv
// Constants and types shared by the instrument status reporting block
package isr_pkg;
	// ==========================================================
	// Abnormal-operation bit positions and layout
	localparam int ABN_W = 16;
	localparam int ABN_OVERVOLTAGE = 0;
	localparam int ABN_OVERCURRENT = 1;
	localparam int ABN_POWER_FAIL = 2;
	localparam int ABN_POWER_LIMIT = 3;
	localparam int ABN_OVERTEMP = 4;
	localparam int ABN_PARALLEL = 5;
	localparam int ABN_INHIBIT = 9;
	localparam int ABN_UNREG = 10;
	localparam logic [15:0] ABN_USED_MASK = 16'h063f;
	localparam logic [15:0] ABN_RISE_RESET = 16'h063f;
	localparam logic [15:0] ABN_FALL_RESET = 16'h0000;
	// ==========================================================
	// Standard event bits
	localparam int BYTE_W = 8;
	localparam int STD_OPC = 0;
	localparam int STD_QUERY_ERR = 2;
	localparam int STD_DEVICE_ERR = 3;
	localparam int STD_EXEC_ERR = 4;
	localparam int STD_SYNTAX_ERR = 5;
	localparam int STD_POWER_ON = 7;
	localparam logic [7:0] STD_RESET = 8'h80;
	// ==========================================================
	// Status summary byte bits
	localparam int SB_ERRQ = 2;
	localparam int SB_ABN = 3;
	localparam int SB_MAV = 4;
	localparam int SB_ESB = 5;
	localparam int SB_RQS = 6;
	localparam int SB_OPER = 7;
	localparam logic [7:0] SRE_USED_MASK = 8'hbf;
	// ==========================================================
	// Queues
	localparam int ERR_W = 16;
	localparam logic [15:0] ERR_OVERFLOW = 16'hfea2;
	localparam logic [15:0] ERR_NONE = 16'h0000;
	localparam int MSG_W = 8;
	localparam int QUEUE_DEPTH = 8;
	// ==========================================================
	// Command codes
	typedef enum logic [4:0] {
		CMD_ABN_COND_RD = 5'h00,
		CMD_ABN_EVENT_RD = 5'h01,
		CMD_ABN_ENABLE_WR = 5'h02,
		CMD_ABN_ENABLE_RD = 5'h03,
		CMD_RISE_WR = 5'h04,
		CMD_RISE_RD = 5'h05,
		CMD_FALL_WR = 5'h06,
		CMD_FALL_RD = 5'h07,
		CMD_STD_EVENT_RD = 5'h08,
		CMD_STD_ENABLE_WR = 5'h09,
		CMD_STD_ENABLE_RD = 5'h0a,
		CMD_STB_RD = 5'h0b,
		CMD_SERIAL_POLL = 5'h0c,
		CMD_SRE_WR = 5'h0d,
		CMD_SRE_RD = 5'h0e,
		CMD_CLEAR_STATUS = 5'h0f,
		CMD_ERR_RD = 5'h10,
		CMD_MSG_RD = 5'h11
	} isr_cmd_t;
endpackage : isr_pkg

// >>> core/isr_top.sv
// Status reporting: abnormal-operation group, standard events, status byte, queues
// What this block does
// - Condition bits 0-5 map the six trips
// - Inhibit bit 9, unregulated bit 10, others zero
// - Condition, edge filters, event latch, enable mask
// - Enabled abnormal events drive status bit 3
// - Standard event register read-only, cleared by read
// - Standard event bit layout, bits 1,6 zero
// - Query error on three buffer faults
// - Power-on bit set after power cycle
// - Enabled standard events drive status bit 5
// - Error queue non-empty drives status bit 2
// - Output queue non-empty drives status bit 4
// - Enabled operation events drive status bit 7
// - Service summary is unlatched OR of enabled bits
// - Status byte query returns summary, clears nothing
// - Service need raises request line and flag
// - Serial poll returns and clears only flag
// - Error queue first-in first-out until read
// - Error overflow replaces newest with overflow code
// - Output queue first-in first-out until read
// - Rising and falling filters qualify condition edges
// - Set event bit ignores further events
// - Condition bits follow live state unlatched
`timescale 1ns/100ps
`default_nettype none
module isr_top
	import isr_pkg::*;
#(
	parameter int DEPTH = QUEUE_DEPTH
) (
	// Clock, reset, enable
	input wire logic I_CLK,
	input wire logic I_RESETN,
	input wire logic I_CE,
	// Monitored instrument state (asynchronous pins)
	input wire logic I_OVERVOLTAGE_TRIP,
	input wire logic I_OVERCURRENT_TRIP,
	input wire logic I_POWER_FAIL_TRIP,
	input wire logic I_POWER_LIMIT_ACTIVE,
	input wire logic I_OVERTEMP_TRIP,
	input wire logic I_PARALLELED_UNIT_TRIP,
	input wire logic I_EXTERNAL_INHIBIT,
	input wire logic I_UNREGULATED_OUTPUT,
	// Events from the command parser (same clock)
	input wire logic I_OPER_SUMMARY,
	input wire logic I_EV_OPC,
	input wire logic I_EV_DEVICE_ERR,
	input wire logic I_EV_EXEC_ERR,
	input wire logic I_EV_SYNTAX_ERR,
	input wire logic I_NEW_LINE,
	input wire logic I_INPUT_FULL,
	// Queue fill side
	input wire logic I_ERR_PUSH,
	input wire logic [ERR_W-1:0] I_ERR_CODE,
	input wire logic I_MSG_PUSH,
	input wire logic [MSG_W-1:0] I_MSG_DATA,
	// Command port
	input wire logic I_CMD_VALID,
	input wire logic [4:0] I_CMD_CODE,
	input wire logic [ERR_W-1:0] I_CMD_DATA,
	// Answers
	output logic O_RESP_VALID,
	output logic [ERR_W-1:0] O_RESP_DATA,
	output logic O_SRQ
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
	localparam logic [CW-1:0] CNT_ONE = CW'(1);
	localparam logic [PW-1:0] PTR_ONE = PW'(1);

	function automatic logic is_cmd(input logic [4:0] code, input isr_cmd_t c);
		return I_CMD_VALID && (code == c);
	endfunction : is_cmd

	// ==========================================================
	// Condition synchroniser
	logic [ABN_W-1:0] pins;
	logic [ABN_W-1:0] cond_meta_reg, cond_meta_next;
	logic [ABN_W-1:0] cond_reg, cond_next;
	logic [ABN_W-1:0] cond_last_reg, cond_last_next;
	always_comb begin
		pins = '0;
		pins[ABN_OVERVOLTAGE] = I_OVERVOLTAGE_TRIP;
		pins[ABN_OVERCURRENT] = I_OVERCURRENT_TRIP;
		pins[ABN_POWER_FAIL] = I_POWER_FAIL_TRIP;
		pins[ABN_POWER_LIMIT] = I_POWER_LIMIT_ACTIVE;
		pins[ABN_OVERTEMP] = I_OVERTEMP_TRIP;
		pins[ABN_PARALLEL] = I_PARALLELED_UNIT_TRIP;
		pins[ABN_INHIBIT] = I_EXTERNAL_INHIBIT;
		pins[ABN_UNREG] = I_UNREGULATED_OUTPUT;
		cond_meta_next = pins & ABN_USED_MASK;
		cond_next = cond_meta_reg;
		cond_last_next = cond_reg;
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			cond_meta_reg <= '0;
			cond_reg <= '0;
			cond_last_reg <= '0;
		end else if (I_CE) begin
			cond_meta_reg <= cond_meta_next;
			cond_reg <= cond_next;
			cond_last_reg <= cond_last_next;
		end
	end

	// ==========================================================
	// Abnormal-operation group and standard events
	logic cls;
	logic [ABN_W-1:0] abn_event_reg, abn_event_next, abn_enable_reg, abn_enable_next;
	logic [ABN_W-1:0] rise_reg, rise_next, fall_reg, fall_next, abn_hits;
	logic [BYTE_W-1:0] std_event_reg, std_event_next, std_enable_reg, std_enable_next;
	logic [BYTE_W-1:0] std_set;
	logic [CW-1:0] msg_count_reg;
	// Procedural, so the valid line read inside the function is in the sensitivity
	always_comb cls = is_cmd(I_CMD_CODE, CMD_CLEAR_STATUS);
	always_comb begin
		// Edge filters select which condition changes become events
		abn_hits = ((cond_reg & ~cond_last_reg & rise_reg)
			| (~cond_reg & cond_last_reg & fall_reg)) & ABN_USED_MASK;
		// Clear then OR in new hits, so a same-cycle event survives
		abn_event_next = abn_event_reg;
		if (cls || is_cmd(I_CMD_CODE, CMD_ABN_EVENT_RD))
			abn_event_next = '0;
		abn_event_next = abn_event_next | abn_hits;
		abn_enable_next = abn_enable_reg;
		rise_next = rise_reg;
		fall_next = fall_reg;
		if (is_cmd(I_CMD_CODE, CMD_ABN_ENABLE_WR))
			abn_enable_next = I_CMD_DATA & ABN_USED_MASK;
		if (is_cmd(I_CMD_CODE, CMD_RISE_WR))
			rise_next = I_CMD_DATA & ABN_USED_MASK;
		if (is_cmd(I_CMD_CODE, CMD_FALL_WR))
			fall_next = I_CMD_DATA & ABN_USED_MASK;
		std_set = '0;
		std_set[STD_OPC] = I_EV_OPC;
		std_set[STD_DEVICE_ERR] = I_EV_DEVICE_ERR;
		std_set[STD_EXEC_ERR] = I_EV_EXEC_ERR;
		std_set[STD_SYNTAX_ERR] = I_EV_SYNTAX_ERR;
		std_set[STD_QUERY_ERR] = (is_cmd(I_CMD_CODE, CMD_MSG_RD) && msg_count_reg == '0)
			|| (I_NEW_LINE && msg_count_reg != '0)
			|| (I_INPUT_FULL && msg_count_reg == FULL_CNT);
		std_event_next = std_event_reg;
		if (cls || is_cmd(I_CMD_CODE, CMD_STD_EVENT_RD))
			std_event_next = '0;
		std_event_next = std_event_next | std_set;
		std_enable_next = std_enable_reg;
		if (is_cmd(I_CMD_CODE, CMD_STD_ENABLE_WR))
			std_enable_next = I_CMD_DATA[BYTE_W-1:0];
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			abn_event_reg <= '0;
			abn_enable_reg <= '0;
			rise_reg <= ABN_RISE_RESET;
			fall_reg <= ABN_FALL_RESET;
			std_event_reg <= STD_RESET;
			std_enable_reg <= '0;
		end else if (I_CE) begin
			abn_event_reg <= abn_event_next;
			abn_enable_reg <= abn_enable_next;
			rise_reg <= rise_next;
			fall_reg <= fall_next;
			std_event_reg <= std_event_next;
			std_enable_reg <= std_enable_next;
		end
	end

	// ==========================================================
	// Error queue and output queue
	logic [ERR_W-1:0] err_mem_reg [DEPTH], err_mem_next [DEPTH];
	logic [MSG_W-1:0] msg_mem_reg [DEPTH], msg_mem_next [DEPTH];
	logic [PW-1:0] err_rd_reg, err_rd_next, err_wr_reg, err_wr_next;
	logic [PW-1:0] msg_rd_reg, msg_rd_next, msg_wr_reg, msg_wr_next;
	logic [CW-1:0] err_count_reg, err_count_next, msg_count_next;
	logic err_pop, msg_pop;
	always_comb begin
		err_mem_next = err_mem_reg;
		msg_mem_next = msg_mem_reg;
		err_pop = is_cmd(I_CMD_CODE, CMD_ERR_RD) && err_count_reg != '0;
		msg_pop = is_cmd(I_CMD_CODE, CMD_MSG_RD) && msg_count_reg != '0;
		err_rd_next = err_pop ? err_rd_reg + PTR_ONE : err_rd_reg;
		err_count_next = err_pop ? err_count_reg - CNT_ONE : err_count_reg;
		err_wr_next = err_wr_reg;
		if (I_ERR_PUSH) begin
			if (err_count_next != FULL_CNT) begin
				err_mem_next[err_wr_reg] = I_ERR_CODE;
				err_wr_next = err_wr_reg + PTR_ONE;
				err_count_next = err_count_next + CNT_ONE;
			end else begin
				err_mem_next[err_wr_reg - PTR_ONE] = ERR_OVERFLOW;
			end
		end
		if (cls) begin
			err_rd_next = '0;
			err_wr_next = '0;
			err_count_next = '0;
		end
		msg_rd_next = msg_pop ? msg_rd_reg + PTR_ONE : msg_rd_reg;
		msg_count_next = msg_pop ? msg_count_reg - CNT_ONE : msg_count_reg;
		msg_wr_next = msg_wr_reg;
		// A full queue drops the message; the parser sees it as a query error
		if (I_MSG_PUSH && msg_count_next != FULL_CNT) begin
			msg_mem_next[msg_wr_reg] = I_MSG_DATA;
			msg_wr_next = msg_wr_reg + PTR_ONE;
			msg_count_next = msg_count_next + CNT_ONE;
		end
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			for (int i = 0; i < DEPTH; i++) begin
				err_mem_reg[i] <= ERR_NONE;
				msg_mem_reg[i] <= '0;
			end
			err_rd_reg <= '0;
			err_wr_reg <= '0;
			err_count_reg <= '0;
			msg_rd_reg <= '0;
			msg_wr_reg <= '0;
			msg_count_reg <= '0;
		end else if (I_CE) begin
			err_mem_reg <= err_mem_next;
			msg_mem_reg <= msg_mem_next;
			err_rd_reg <= err_rd_next;
			err_wr_reg <= err_wr_next;
			err_count_reg <= err_count_next;
			msg_rd_reg <= msg_rd_next;
			msg_wr_reg <= msg_wr_next;
			msg_count_reg <= msg_count_next;
		end
	end

	// ==========================================================
	// Status byte, service request and answers
	logic [BYTE_W-1:0] stb, sre_reg, sre_next;
	logic service_summary, mss_last_reg, mss_last_next, rqs_reg, rqs_next, poll;
	logic resp_valid_next;
	logic [ERR_W-1:0] resp_data_next;
	always_comb poll = is_cmd(I_CMD_CODE, CMD_SERIAL_POLL);
	always_comb begin
		stb = '0;
		stb[SB_ERRQ] = err_count_reg != '0;
		stb[SB_ABN] = |(abn_event_reg & abn_enable_reg);
		stb[SB_MAV] = msg_count_reg != '0;
		stb[SB_ESB] = |(std_event_reg & std_enable_reg);
		stb[SB_OPER] = I_OPER_SUMMARY;
		service_summary = |(stb & sre_reg);
		mss_last_next = service_summary;
		// New reason for service raises the flag; set wins over poll clear
		rqs_next = (rqs_reg && !poll) || (service_summary && !mss_last_reg);
		sre_next = is_cmd(I_CMD_CODE, CMD_SRE_WR) ? I_CMD_DATA[BYTE_W-1:0] & SRE_USED_MASK
			: sre_reg;
		resp_valid_next = I_CMD_VALID;
		resp_data_next = '0;
		if (I_CMD_VALID) begin
			unique case (I_CMD_CODE)
				CMD_ABN_COND_RD: resp_data_next = cond_reg;
				CMD_ABN_EVENT_RD: resp_data_next = abn_event_reg;
				CMD_ABN_ENABLE_RD: resp_data_next = abn_enable_reg;
				CMD_RISE_RD: resp_data_next = rise_reg;
				CMD_FALL_RD: resp_data_next = fall_reg;
				CMD_STD_EVENT_RD: resp_data_next = {8'h00, std_event_reg};
				CMD_STD_ENABLE_RD: resp_data_next = {8'h00, std_enable_reg};
				CMD_SRE_RD: resp_data_next = {8'h00, sre_reg};
				CMD_STB_RD: begin
					resp_data_next = {8'h00, stb};
					resp_data_next[SB_RQS] = service_summary;
				end
				CMD_SERIAL_POLL: begin
					resp_data_next = {8'h00, stb};
					resp_data_next[SB_RQS] = rqs_reg;
				end
				CMD_ERR_RD: resp_data_next = err_pop ? err_mem_reg[err_rd_reg] : ERR_NONE;
				CMD_MSG_RD: resp_data_next = {8'h00, msg_pop ? msg_mem_reg[msg_rd_reg] : 8'h00};
				default: resp_data_next = '0;
			endcase
		end
	end
	always_ff @(posedge I_CLK) begin
		if (!I_RESETN) begin
			sre_reg <= '0;
			mss_last_reg <= 1'b0;
			rqs_reg <= 1'b0;
			O_SRQ <= 1'b0;
			O_RESP_VALID <= 1'b0;
			O_RESP_DATA <= '0;
		end else if (I_CE) begin
			sre_reg <= sre_next;
			mss_last_reg <= mss_last_next;
			rqs_reg <= rqs_next;
			O_SRQ <= rqs_next;
			O_RESP_VALID <= resp_valid_next;
			O_RESP_DATA <= resp_data_next;
		end
	end

	// ==========================================================
	// Checks
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);
	abn_reserved_a: assert property ((abn_event_reg & ~ABN_USED_MASK) == '0)
		else $error("abnormal event has reserved bit set");
	event_latch_a: assert property (I_CE && !cls && !is_cmd(I_CMD_CODE, CMD_ABN_EVENT_RD)
		|=> (abn_event_reg & $past(abn_event_reg)) == $past(abn_event_reg))
		else $error("latched abnormal event bit dropped");
	std_clear_a: assert property (I_CE && is_cmd(I_CMD_CODE, CMD_STD_EVENT_RD) && std_set == '0
		|=> std_event_reg == '0 && O_RESP_DATA[BYTE_W-1:0] == $past(std_event_reg))
		else $error("standard event read did not clear");
	stb_mss_a: assert property (I_CE && is_cmd(I_CMD_CODE, CMD_STB_RD)
		|=> O_RESP_VALID && O_RESP_DATA[SB_RQS] == $past(service_summary))
		else $error("status byte query lost service summary");
	esb_sum_a: assert property (I_CE && (std_event_reg & std_enable_reg) != '0
		&& is_cmd(I_CMD_CODE, CMD_STB_RD) |=> O_RESP_DATA[SB_ESB])
		else $error("event summary bit missing");
	srq_raise_a: assert property (I_CE && service_summary && !mss_last_reg |=> O_SRQ && rqs_reg)
		else $error("service request not raised");
	poll_clear_a: assert property (I_CE && poll && !(service_summary && !mss_last_reg)
		|=> !O_SRQ && O_RESP_DATA[SB_RQS] == $past(rqs_reg))
		else $error("serial poll did not return and clear flag");
	err_ovf_a: assert property (I_CE && I_ERR_PUSH && !err_pop && !cls
		&& err_count_reg == FULL_CNT |=> err_count_reg == FULL_CNT
		&& err_mem_reg[err_wr_reg - PTR_ONE] == ERR_OVERFLOW)
		else $error("error overflow not recorded in newest entry");
	errq_bit_a: assert property (I_CE && err_count_reg != '0 && is_cmd(I_CMD_CODE, CMD_STB_RD)
		|=> O_RESP_DATA[SB_ERRQ])
		else $error("error queue summary bit missing");
endmodule : isr_top
`default_nettype wire

// >>> tb/isr_ctrl_model.sv
// Remote controller model: issues commands and collects the answers
`timescale 1ns/100ps
`default_nettype none
module isr_ctrl_model (
	// Testbench side
	input wire logic i_clk,
	input wire logic i_go,
	input wire logic [4:0] i_code,
	input wire logic [15:0] i_data,
	output logic [15:0] o_answer,
	// Device side
	output logic o_cmd_valid,
	output logic [4:0] o_cmd_code,
	output logic [15:0] o_cmd_data,
	input wire logic i_resp_valid,
	input wire logic [15:0] i_resp_data
);
	logic [4:0] idle_code = 5'h15;
	logic [15:0] idle_data = 16'h5a5a;
	// Idle lines toggle so a stale request never looks held
	always @(posedge i_clk) begin
		idle_code <= ~idle_code;
		idle_data <= ~idle_data;
		if (i_resp_valid) begin
			o_answer <= i_resp_data;
		end
	end
	assign o_cmd_valid = i_go;
	assign o_cmd_code = i_go ? i_code : idle_code;
	assign o_cmd_data = i_go ? i_data : idle_data;
endmodule : isr_ctrl_model
`default_nettype wire

// >>> tb/instrument_status_reporting_test.sv
// Self-checking testbench for the status reporting block
`timescale 1ns/100ps
`default_nettype none
module instrument_status_reporting_test;
	import isr_pkg::*;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic go = 1'b0;
	logic [4:0] code = 5'h00;
	logic [15:0] dat = 16'h0000;
	logic [15:0] qd = 16'h0000;
	logic [7:0] pins = 8'h00;
	logic [7:0] ev = 8'h00;
	logic oper = 1'b0;
	logic ce = 1'b1;
	logic cv;
	logic [4:0] cc;
	logic [15:0] cd;
	logic rv;
	logic [15:0] rdat;
	logic [15:0] ans;
	logic srq;
	int n_fail = 0;
	int checks = 0;
	int pos [8] = '{0, 1, 2, 3, 4, 5, 9, 10};
	always #25 clk = ~clk;
	// ==========================================================
	// Device and controller
	// Small queues so overflow is reached quickly
	isr_top #(.DEPTH(2)) u_isr_top (
		.I_CLK(clk), .I_RESETN(rstn), .I_CE(ce),
		.I_OVERVOLTAGE_TRIP(pins[0]), .I_OVERCURRENT_TRIP(pins[1]),
		.I_POWER_FAIL_TRIP(pins[2]), .I_POWER_LIMIT_ACTIVE(pins[3]),
		.I_OVERTEMP_TRIP(pins[4]), .I_PARALLELED_UNIT_TRIP(pins[5]),
		.I_EXTERNAL_INHIBIT(pins[6]), .I_UNREGULATED_OUTPUT(pins[7]),
		.I_OPER_SUMMARY(oper), .I_EV_OPC(ev[0]), .I_EV_DEVICE_ERR(ev[1]),
		.I_EV_EXEC_ERR(ev[2]), .I_EV_SYNTAX_ERR(ev[3]), .I_NEW_LINE(ev[4]),
		.I_INPUT_FULL(ev[7]), .I_ERR_PUSH(ev[5]), .I_ERR_CODE(qd),
		.I_MSG_PUSH(ev[6]), .I_MSG_DATA(qd[7:0]), .I_CMD_VALID(cv),
		.I_CMD_CODE(cc), .I_CMD_DATA(cd), .O_RESP_VALID(rv),
		.O_RESP_DATA(rdat), .O_SRQ(srq)
	);
	isr_ctrl_model u_isr_ctrl_model (
		.i_clk(clk), .i_go(go), .i_code(code), .i_data(dat), .o_answer(ans),
		.o_cmd_valid(cv), .o_cmd_code(cc), .o_cmd_data(cd),
		.i_resp_valid(rv), .i_resp_data(rdat)
	);
	// ==========================================================
	// Tasks
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("BAD t=%0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [4:0] c, input logic [15:0] d);
		int n = 0;
		@(negedge clk);
		go = 1'b1;
		code = c;
		dat = d;
		@(negedge clk);
		go = 1'b0;
		while (rv !== 1'b1 && n < 4) begin
			@(negedge clk);
			n++;
		end
		chk({15'h0000, rv}, 16'h0001);
		// One more edge lets the controller capture the answer
		@(negedge clk);
	endtask : wr
	task automatic rd(input logic [4:0] c, input logic [15:0] e);
		wr(c, 16'h0000);
		chk(ans, e);
	endtask : rd
	task automatic pulse(input int k, input logic [15:0] d);
		@(negedge clk);
		ev[k] = 1'b1;
		qd = d;
		@(negedge clk);
		ev[k] = 1'b0;
	endtask : pulse
	// Pins pass two synchronising flops before they count
	task automatic setp(input logic [7:0] v);
		@(negedge clk);
		pins = v;
		repeat (5) @(negedge clk);
	endtask : setp
	task automatic fin(input string s);
		$display("test %s done", s);
	endtask : fin
	task automatic close_out;
		$display("checks=%0d n_fail=%0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out
	// ==========================================================
	// Tests
	initial begin
		repeat (5) @(negedge clk);
		rstn = 1'b1;
		rd(CMD_STD_EVENT_RD, 16'h0080);
		rd(CMD_STD_EVENT_RD, 16'h0000);
		fin("reset");
		for (int i = 0; i < 8; i++) begin
			setp(8'h01 << i);
			rd(CMD_ABN_COND_RD, 16'h0001 << pos[i]);
			setp(8'h00);
		end
		rd(CMD_ABN_EVENT_RD, 16'h063f);
		rd(CMD_ABN_EVENT_RD, 16'h0000);
		wr(CMD_RISE_WR, 16'h0000);
		wr(CMD_FALL_WR, 16'h0200);
		setp(8'h40);
		rd(CMD_ABN_EVENT_RD, 16'h0000);
		setp(8'h00);
		rd(CMD_ABN_EVENT_RD, 16'h0200);
		wr(CMD_RISE_WR, 16'h063f);
		wr(CMD_FALL_WR, 16'h0000);
		fin("abnormal group");
		wr(CMD_ABN_ENABLE_WR, 16'h0200);
		setp(8'h40);
		rd(CMD_STB_RD, 16'h0008);
		wr(CMD_SRE_WR, 16'h0008);
		repeat (2) @(negedge clk);
		chk({15'h0000, srq}, 16'h0001);
		rd(CMD_STB_RD, 16'h0048);
		chk({15'h0000, srq}, 16'h0001);
		rd(CMD_SERIAL_POLL, 16'h0048);
		chk({15'h0000, srq}, 16'h0000);
		rd(CMD_ABN_EVENT_RD, 16'h0200);
		rd(CMD_STB_RD, 16'h0000);
		setp(8'h00);
		fin("service request");
		for (int k = 0; k < 4; k++) begin
			pulse(k, 16'h0000);
		end
		wr(CMD_STD_ENABLE_WR, 16'h003d);
		rd(CMD_STB_RD, 16'h0020);
		rd(CMD_STD_EVENT_RD, 16'h0039);
		rd(CMD_STB_RD, 16'h0000);
		wr(CMD_STD_ENABLE_WR, 16'h0000);
		rd(CMD_MSG_RD, 16'h0000);
		rd(CMD_STD_EVENT_RD, 16'h0004);
		fin("standard events");
		pulse(6, 16'h00a5);
		pulse(6, 16'h005a);
		rd(CMD_STB_RD, 16'h0010);
		pulse(4, 16'h0000);
		rd(CMD_STD_EVENT_RD, 16'h0004);
		pulse(7, 16'h0000);
		rd(CMD_STD_EVENT_RD, 16'h0004);
		rd(CMD_MSG_RD, 16'h00a5);
		rd(CMD_MSG_RD, 16'h005a);
		rd(CMD_STB_RD, 16'h0000);
		oper = 1'b1;
		rd(CMD_STB_RD, 16'h0080);
		oper = 1'b0;
		fin("output queue");
		pulse(5, 16'h1111);
		pulse(5, 16'h2222);
		rd(CMD_STB_RD, 16'h0004);
		rd(CMD_ERR_RD, 16'h1111);
		rd(CMD_ERR_RD, 16'h2222);
		pulse(5, 16'h1111);
		pulse(5, 16'h2222);
		pulse(5, 16'h3333);
		rd(CMD_ERR_RD, 16'h1111);
		rd(CMD_ERR_RD, 16'hfea2);
		rd(CMD_ERR_RD, 16'h0000);
		fin("error queue");
		// Pushes while the enable is low must leave both queues empty
		ce = 1'b0;
		pulse(5, 16'h7777);
		pulse(6, 16'h0077);
		ce = 1'b1;
		rd(CMD_STB_RD, 16'h0000);
		fin("clock enable");
		pulse(5, 16'h4444);
		pulse(2, 16'h0000);
		setp(8'h40);
		wr(CMD_CLEAR_STATUS, 16'h0000);
		rd(CMD_ERR_RD, 16'h0000);
		rd(CMD_STD_EVENT_RD, 16'h0000);
		rd(CMD_ABN_EVENT_RD, 16'h0000);
		rd(CMD_ABN_ENABLE_RD, 16'h0200);
		rd(CMD_ABN_COND_RD, 16'h0200);
		rd(CMD_RISE_RD, 16'h063f);
		rd(CMD_FALL_RD, 16'h0000);
		rd(CMD_SRE_RD, 16'h0008);
		rd(CMD_STD_ENABLE_RD, 16'h0000);
		rd(5'h1f, 16'h0000);
		setp(8'h00);
		fin("clear status");
		close_out();
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		close_out();
	end
endmodule : instrument_status_reporting_test
`default_nettype wire
